// ### hdl/fmc_pkg.sv
package fmc_pkg;

  // register byte offsets on the peripheral bus
  localparam logic [7:0] FMC_OFS_CMD = 8'h00;
  localparam logic [7:0] FMC_OFS_CTRLB = 8'h04;
  localparam logic [7:0] FMC_OFS_INTERRUPT_FLAG_REGISTER = 8'h08;
  localparam logic [7:0] FMC_OFS_STATUS = 8'h0c;
  localparam logic [7:0] FMC_OFS_ADDR = 8'h10;
  localparam logic [7:0] FMC_OFS_LOCK = 8'h14;

  // command register fields
  localparam int FMC_CMD_CODE_LSB = 0;
  localparam int FMC_CMD_KEY_LSB = 8;
  localparam logic [7:0] FMC_CMD_KEY = 8'h5a;

  // control register fields and reset value
  localparam int FMC_CB_RWS_LSB = 1;
  localparam int FMC_CB_MANW_BIT = 7;
  localparam int FMC_CB_SPRM_LSB = 8;
  localparam logic [31:0] FMC_CTRLB_RST = 32'h0000_0080;

  // flag and status bits
  localparam int FMC_IF_READY_BIT = 0;
  localparam int FMC_IF_ERROR_BIT = 1;
  localparam int FMC_ST_PRM_BIT = 0;
  localparam int FMC_ST_LOAD_BIT = 1;
  localparam int FMC_ST_LOCK_ERROR_FLAG_BIT = 2;

  // sleep power reduction settings
  localparam logic [1:0] FMC_SPRM_WAKE_ON_ACCESS = 2'h0;
  localparam logic [1:0] FMC_SPRM_WAKE_AT_EXIT = 2'h1;
  localparam logic [1:0] FMC_SPRM_DISABLED = 2'h3;

  // memory bus map
  localparam logic [31:0] FMC_RWW_BASE = 32'h0040_0000;
  localparam logic [31:0] FMC_RWW_BYTES = 32'h0000_2000;
  localparam logic [31:0] FMC_AUX_BASE = 32'h0080_0000;
  localparam logic [31:0] FMC_AUX_BYTES = 32'h0000_2000;
  localparam logic [31:0] FMC_BOOT_MAX_BYTES = 32'h0000_8000;
  localparam logic [31:0] FMC_EE_MAX_BYTES = 32'h0000_4000;

  // timing counts in core clock cycles
  localparam int FMC_POWERUP_CYCLES = 64;
  localparam int FMC_PROG_CYCLES = 400;
  localparam int FMC_ERASE_CYCLES = 1000;

  localparam logic [1:0] FMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FMC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FMC_PH_POWERUP = 2'b00,
    FMC_PH_IDLE = 2'b01,
    FMC_PH_BUSY = 2'b10
  } fmc_phase_t;

  typedef enum logic [1:0] {
    FMC_SP_MAIN = 2'b00,
    FMC_SP_RWW = 2'b01,
    FMC_SP_AUX = 2'b10,
    FMC_SP_NONE = 2'b11
  } fmc_space_t;

  typedef enum logic [6:0] {
    FMC_CMD_ERASE_ROW = 7'h01,
    FMC_CMD_WRITE_PAGE = 7'h02,
    FMC_CMD_WRITE_AUX_PAGE = 7'h03,
    FMC_CMD_RWW_ERASE_ROW = 7'h04,
    FMC_CMD_RWW_WRITE_PAGE = 7'h05,
    FMC_CMD_LOCK_REGION = 7'h06,
    FMC_CMD_UNLOCK_REGION = 7'h07,
    FMC_CMD_SET_PRM = 7'h08,
    FMC_CMD_CLEAR_PRM = 7'h09,
    FMC_CMD_PBUF_CLEAR = 7'h0a
  } fmc_cmd_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } fmc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fmc_axi_rsp_t;

  typedef struct packed {
    logic req;
    logic we;
    logic dbg;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fmc_mem_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } fmc_mem_rsp_t;

  typedef struct packed {
    logic op_valid;
    logic [6:0] op;
    logic [31:0] op_addr;
    logic [31:0] raddr;
    logic pb_we;
    logic [31:0] pb_addr;
    logic [31:0] pb_wdata;
    logic lowpower;
  } fmc_flash_ctl_t;

endpackage : fmc_pkg

// ### hdl/fmc_top.sv
// Contract
// - flash reads and page-buffer writes use a 32-bit memory-bus slave; all spaces mapped.
// - commands and settings come over a separate 32-bit peripheral-bus slave.
// - the read-while-write array may be programmed while the main array is read.
// - rows hold four pages; erase works on rows, programming on pages.
// - main array splits into 16 equal regions sized by memory size.
// - a lock bit per region blocks program and erase; defaults come from lock_default_i.
// - lock and unlock commands act on the region of the held address until reset.
// - held address is software writable and loaded by each memory-bus write.
// - lock state of every region is readable in the lock register.
// - default locks come from user configuration, applied only when the power-up sequence after reset ends.
// - boot rows protected by locks and boot size; eeprom rows always writable.
// - calibration and auxiliary space read like the main space.
// - power-up sequence stalls memory bus, then loads the default locks from lock_default_i.
// - reads and auto page writes by addressing; other operations by command.
// - a command needs code and key in one write; ready low until done.
// - commands written while ready is low are ignored.
// - read data returned only after the configured read wait states.
// - main reads stall during main program or erase, not during array-two operations.
// - sleep puts flash in low power as the sleep setting selects.
// - writable registers obey the access guard except flags and status.
// - with security set, flash is closed to external debug access.
// - row erase in a locked region is refused and sets the lock error flag.
// - in automatic mode writing the last page word starts the page program in the main and read-while-write spaces, not in auxiliary space.
module fmc_top #(
  parameter int FLASH_KB = 256,
  parameter int PAGE_BYTES = 64,
  parameter int POWERUP_CYCLES = fmc_pkg::FMC_POWERUP_CYCLES,
  parameter int PROG_CYCLES = fmc_pkg::FMC_PROG_CYCLES,
  parameter int ERASE_CYCLES = fmc_pkg::FMC_ERASE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire fmc_pkg::fmc_axi_req_t axi_i,
  output fmc_pkg::fmc_axi_rsp_t axi_o,
  input wire fmc_pkg::fmc_mem_req_t mem_i,
  output fmc_pkg::fmc_mem_rsp_t mem_o,
  input wire logic [31:0] flash_rdata_i,
  output fmc_pkg::fmc_flash_ctl_t flash_o,
  input wire logic guard_wp_i,
  input wire logic sleep_i,
  input wire logic security_i,
  input wire logic [2:0] boot_protect_size_i,
  input wire logic [2:0] eeprom_size_i,
  input wire logic [15:0] lock_default_i
);

  localparam logic [31:0] FLASH_BYTES = 32'(FLASH_KB * 1024);
  localparam int REG_SHIFT = $clog2(FLASH_KB * 1024 / 16);
  localparam int PAGE_SHIFT = $clog2(PAGE_BYTES);
  localparam logic [15:0] PROG_CNT = 16'(PROG_CYCLES);
  localparam logic [15:0] ERASE_CNT = 16'(ERASE_CYCLES);
  localparam logic [15:0] POWERUP_CNT = 16'(POWERUP_CYCLES);

  if (!(FLASH_KB == 32 || FLASH_KB == 64 || FLASH_KB == 128 || FLASH_KB == 256)) begin : g_bad_size
    $error("flash size must be 32, 64, 128 or 256 KB");
  end
  if (PAGE_BYTES < 8 || (1 << PAGE_SHIFT) != PAGE_BYTES) begin : g_bad_page
    $error("page size must be a power of two of at least 8 bytes");
  end
  if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || POWERUP_CYCLES < 1 || ERASE_CYCLES > 65535
      || PROG_CYCLES > 65535 || POWERUP_CYCLES > 65535) begin : g_bad_time
    $error("operation counts must lie between 1 and 65535");
  end

  typedef struct packed {
    fmc_pkg::fmc_phase_t phase;
    logic [15:0] cnt;
    logic busy_rww;
    logic ready;
    logic error;
    logic lock_error_flag;
    logic prm;
    logic load;
    logic [3:0] rws;
    logic manw;
    logic [1:0] sprm;
    logic [31:0] addr;
    logic [15:0] lock;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    fmc_pkg::fmc_axi_rsp_t axi;
    logic rd_pend;
    logic [3:0] rd_cnt;
    fmc_pkg::fmc_mem_rsp_t mem;
    fmc_pkg::fmc_flash_ctl_t fl;
  } fmc_state_t;

  fmc_state_t s;
  fmc_state_t next_s;

  function automatic fmc_pkg::fmc_space_t space_of(input logic [31:0] a);
    if (a < FLASH_BYTES) begin
      return fmc_pkg::FMC_SP_MAIN;
    end else if (a >= fmc_pkg::FMC_RWW_BASE && a < fmc_pkg::FMC_RWW_BASE + fmc_pkg::FMC_RWW_BYTES) begin
      return fmc_pkg::FMC_SP_RWW;
    end else if (a >= fmc_pkg::FMC_AUX_BASE && a < fmc_pkg::FMC_AUX_BASE + fmc_pkg::FMC_AUX_BYTES) begin
      return fmc_pkg::FMC_SP_AUX;
    end else begin
      return fmc_pkg::FMC_SP_NONE;
    end
  endfunction : space_of

  function automatic logic [3:0] region_of(input logic [31:0] a);
    return a[REG_SHIFT +: 4];
  endfunction : region_of

  function automatic logic is_protected(input logic [31:0] a, input logic [15:0] lk,
                                        input logic [2:0] bp, input logic [2:0] ee);
    logic [31:0] boot_bytes;
    logic [31:0] ee_bytes;
    boot_bytes = (bp == 3'h7) ? 32'h0 : (fmc_pkg::FMC_BOOT_MAX_BYTES >> bp);
    ee_bytes = (ee == 3'h7) ? 32'h0 : (fmc_pkg::FMC_EE_MAX_BYTES >> ee);
    if (a < boot_bytes) begin
      return 1'b1;
    end
    if (a >= FLASH_BYTES - ee_bytes) begin
      return 1'b0;
    end
    return lk[region_of(a)];
  endfunction : is_protected

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  logic [31:0] ctrlb_word;
  logic [31:0] interrupt_flag_register_word;
  logic [31:0] status_word;

  always_comb begin
    ctrlb_word = 32'h0;
    ctrlb_word[fmc_pkg::FMC_CB_RWS_LSB +: 4] = s.rws;
    ctrlb_word[fmc_pkg::FMC_CB_MANW_BIT] = s.manw;
    ctrlb_word[fmc_pkg::FMC_CB_SPRM_LSB +: 2] = s.sprm;
    interrupt_flag_register_word = 32'h0;
    interrupt_flag_register_word[fmc_pkg::FMC_IF_READY_BIT] = s.ready;
    interrupt_flag_register_word[fmc_pkg::FMC_IF_ERROR_BIT] = s.error;
    status_word = 32'h0;
    status_word[fmc_pkg::FMC_ST_PRM_BIT] = s.prm;
    status_word[fmc_pkg::FMC_ST_LOAD_BIT] = s.load;
    status_word[fmc_pkg::FMC_ST_LOCK_ERROR_FLAG_BIT] = s.lock_error_flag;
  end

  always_comb begin
    logic start_req;
    logic [6:0] start_code;
    logic [31:0] start_addr;
    logic cmd_write;
    logic [31:0] wr_word;
    logic [31:0] ma;
    fmc_pkg::fmc_space_t sp;
    logic stall_rd;
    logic stall_wr;
    start_req = 1'b0;
    start_code = 7'h0;
    start_addr = 32'h0;
    cmd_write = s.aw_got && s.w_got && !s.axi.bvalid;
    wr_word = 32'h0;
    ma = mem_i.addr;
    sp = space_of(mem_i.addr);
    stall_rd = s.phase == fmc_pkg::FMC_PH_POWERUP || (s.phase == fmc_pkg::FMC_PH_BUSY
               && (!s.busy_rww || sp == fmc_pkg::FMC_SP_RWW));
    stall_wr = s.phase != fmc_pkg::FMC_PH_IDLE || cmd_write;
    next_s = s;
    next_s.fl.op_valid = 1'b0;
    next_s.fl.pb_we = 1'b0;
    next_s.mem.ack = 1'b0;
    next_s.mem.err = 1'b0;

    // operation timing and power-up sequence
    case (s.phase)
      fmc_pkg::FMC_PH_POWERUP: begin
        if (s.cnt == POWERUP_CNT - 16'h1) begin
          next_s.phase = fmc_pkg::FMC_PH_IDLE;
          next_s.ready = 1'b1;
          next_s.lock = lock_default_i;
        end else begin
          next_s.cnt = s.cnt + 16'h1;
        end
      end
      fmc_pkg::FMC_PH_BUSY: begin
        if (s.cnt == 16'h1) begin
          next_s.phase = fmc_pkg::FMC_PH_IDLE;
          next_s.ready = 1'b1;
          next_s.busy_rww = 1'b0;
        end else begin
          next_s.cnt = s.cnt - 16'h1;
        end
      end
      default: begin
      end
    endcase

    // peripheral bus write channel
    if (axi_i.awvalid && s.axi.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = axi_i.awaddr[7:0];
    end
    if (axi_i.wvalid && s.axi.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_i.wdata;
      next_s.wstrb = axi_i.wstrb;
    end
    if (s.axi.bvalid && axi_i.bready) begin
      next_s.axi.bvalid = 1'b0;
    end
    if (cmd_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.axi.bvalid = 1'b1;
      next_s.axi.bresp = fmc_pkg::FMC_RESP_OKAY;
      if (s.aw_addr == fmc_pkg::FMC_OFS_INTERRUPT_FLAG_REGISTER) begin
        if (s.wstrb[0] && s.wdata[fmc_pkg::FMC_IF_ERROR_BIT]) begin
          next_s.error = 1'b0;
        end
      end else if (s.aw_addr == fmc_pkg::FMC_OFS_STATUS) begin
        if (s.wstrb[0] && s.wdata[fmc_pkg::FMC_ST_LOCK_ERROR_FLAG_BIT]) begin
          next_s.lock_error_flag = 1'b0;
        end
      end else if (s.aw_addr == fmc_pkg::FMC_OFS_LOCK) begin
        next_s.axi.bresp = fmc_pkg::FMC_RESP_SLVERR;
      end else if (s.aw_addr != fmc_pkg::FMC_OFS_CMD && s.aw_addr != fmc_pkg::FMC_OFS_CTRLB
                   && s.aw_addr != fmc_pkg::FMC_OFS_ADDR) begin
        next_s.axi.bresp = fmc_pkg::FMC_RESP_SLVERR;
      end else if (guard_wp_i) begin
        next_s.axi.bresp = fmc_pkg::FMC_RESP_SLVERR;
      end else if (s.aw_addr == fmc_pkg::FMC_OFS_CTRLB) begin
        wr_word = merge_strb(ctrlb_word, s.wdata, s.wstrb);
        next_s.rws = wr_word[fmc_pkg::FMC_CB_RWS_LSB +: 4];
        next_s.manw = wr_word[fmc_pkg::FMC_CB_MANW_BIT];
        next_s.sprm = wr_word[fmc_pkg::FMC_CB_SPRM_LSB +: 2];
      end else if (s.aw_addr == fmc_pkg::FMC_OFS_ADDR) begin
        next_s.addr = merge_strb(s.addr, s.wdata, s.wstrb);
      end else begin
        if (s.wstrb[1:0] == 2'b11 && s.wdata[fmc_pkg::FMC_CMD_KEY_LSB +: 8] == fmc_pkg::FMC_CMD_KEY
            && s.ready && s.phase == fmc_pkg::FMC_PH_IDLE) begin
          start_req = 1'b1;
          start_code = s.wdata[fmc_pkg::FMC_CMD_CODE_LSB +: 7];
          start_addr = s.addr;
        end
      end
    end

    // peripheral bus read channel
    if (s.axi.rvalid && axi_i.rready) begin
      next_s.axi.rvalid = 1'b0;
    end
    if (axi_i.arvalid && s.axi.arready) begin
      next_s.axi.rvalid = 1'b1;
      next_s.axi.rresp = fmc_pkg::FMC_RESP_OKAY;
      if (axi_i.araddr[7:0] == fmc_pkg::FMC_OFS_CMD) begin
        next_s.axi.rdata = 32'h0;
      end else if (axi_i.araddr[7:0] == fmc_pkg::FMC_OFS_CTRLB) begin
        next_s.axi.rdata = ctrlb_word;
      end else if (axi_i.araddr[7:0] == fmc_pkg::FMC_OFS_INTERRUPT_FLAG_REGISTER) begin
        next_s.axi.rdata = interrupt_flag_register_word;
      end else if (axi_i.araddr[7:0] == fmc_pkg::FMC_OFS_STATUS) begin
        next_s.axi.rdata = status_word;
      end else if (axi_i.araddr[7:0] == fmc_pkg::FMC_OFS_ADDR) begin
        next_s.axi.rdata = s.addr;
      end else if (axi_i.araddr[7:0] == fmc_pkg::FMC_OFS_LOCK) begin
        next_s.axi.rdata = {16'h0, s.lock};
      end else begin
        next_s.axi.rdata = 32'h0;
        next_s.axi.rresp = fmc_pkg::FMC_RESP_SLVERR;
      end
    end

    // memory bus
    if (s.rd_pend) begin
      if (s.rd_cnt == 4'h0) begin
        next_s.rd_pend = 1'b0;
        next_s.mem.ack = 1'b1;
        next_s.mem.rdata = flash_rdata_i;
      end else begin
        next_s.rd_cnt = s.rd_cnt - 4'h1;
      end
    end else if (mem_i.req && !s.mem.ack) begin
      if (sp == fmc_pkg::FMC_SP_NONE || (security_i && mem_i.dbg)) begin
        next_s.mem.ack = 1'b1;
        next_s.mem.err = 1'b1;
        next_s.mem.rdata = 32'h0;
      end else if (mem_i.we) begin
        if (!stall_wr) begin
          next_s.addr = ma;
          next_s.fl.pb_we = 1'b1;
          next_s.fl.pb_addr = ma;
          next_s.fl.pb_wdata = mem_i.wdata;
          next_s.load = 1'b1;
          next_s.mem.ack = 1'b1;
          if (!s.manw && ma[PAGE_SHIFT-1:2] == '1 && sp != fmc_pkg::FMC_SP_AUX) begin
            start_req = 1'b1;
            start_addr = ma;
            start_code = (sp == fmc_pkg::FMC_SP_RWW) ? fmc_pkg::FMC_CMD_RWW_WRITE_PAGE
                                                      : fmc_pkg::FMC_CMD_WRITE_PAGE;
          end
        end
      end else if (!stall_rd) begin
        next_s.rd_pend = 1'b1;
        next_s.rd_cnt = s.rws;
        next_s.fl.raddr = ma;
      end
    end

    // command execution
    if (start_req) begin
      next_s.ready = 1'b0;
      next_s.phase = fmc_pkg::FMC_PH_BUSY;
      next_s.busy_rww = 1'b0;
      next_s.cnt = 16'h1;
      next_s.fl.op_valid = 1'b1;
      next_s.fl.op = start_code;
      next_s.fl.op_addr = start_addr;
      case (start_code)
        fmc_pkg::FMC_CMD_ERASE_ROW: begin
          if (is_protected(start_addr, s.lock, boot_protect_size_i, eeprom_size_i)) begin
            next_s.lock_error_flag = 1'b1;
            next_s.fl.op_valid = 1'b0;
          end else begin
            next_s.cnt = ERASE_CNT;
            next_s.fl.op_addr = {start_addr[31:PAGE_SHIFT+2], {(PAGE_SHIFT+2){1'b0}}};
          end
        end
        fmc_pkg::FMC_CMD_WRITE_PAGE: begin
          if (is_protected(start_addr, s.lock, boot_protect_size_i, eeprom_size_i)) begin
            next_s.lock_error_flag = 1'b1;
            next_s.fl.op_valid = 1'b0;
          end else begin
            next_s.cnt = PROG_CNT;
            next_s.load = 1'b0;
            next_s.fl.op_addr = {start_addr[31:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
          end
        end
        fmc_pkg::FMC_CMD_WRITE_AUX_PAGE: begin
          next_s.cnt = PROG_CNT;
          next_s.load = 1'b0;
        end
        fmc_pkg::FMC_CMD_RWW_ERASE_ROW: begin
          next_s.cnt = ERASE_CNT;
          next_s.busy_rww = 1'b1;
        end
        fmc_pkg::FMC_CMD_RWW_WRITE_PAGE: begin
          next_s.cnt = PROG_CNT;
          next_s.busy_rww = 1'b1;
          next_s.load = 1'b0;
        end
        fmc_pkg::FMC_CMD_LOCK_REGION: begin
          next_s.lock[region_of(start_addr)] = 1'b1;
        end
        fmc_pkg::FMC_CMD_UNLOCK_REGION: begin
          next_s.lock[region_of(start_addr)] = 1'b0;
        end
        fmc_pkg::FMC_CMD_SET_PRM: begin
          next_s.prm = 1'b1;
        end
        fmc_pkg::FMC_CMD_CLEAR_PRM: begin
          next_s.prm = 1'b0;
        end
        fmc_pkg::FMC_CMD_PBUF_CLEAR: begin
          next_s.load = 1'b0;
        end
        default: begin
          next_s.error = 1'b1;
          next_s.fl.op_valid = 1'b0;
        end
      endcase
    end

    next_s.fl.lowpower = s.prm || (sleep_i && s.sprm != fmc_pkg::FMC_SPRM_DISABLED);
    next_s.axi.awready = !next_s.aw_got && !next_s.axi.bvalid;
    next_s.axi.wready = !next_s.w_got && !next_s.axi.bvalid;
    next_s.axi.arready = !next_s.axi.rvalid;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.phase <= fmc_pkg::FMC_PH_POWERUP;
      s.manw <= fmc_pkg::FMC_CTRLB_RST[fmc_pkg::FMC_CB_MANW_BIT];
      s.rws <= fmc_pkg::FMC_CTRLB_RST[fmc_pkg::FMC_CB_RWS_LSB +: 4];
      s.sprm <= fmc_pkg::FMC_CTRLB_RST[fmc_pkg::FMC_CB_SPRM_LSB +: 2];
    end else begin
      s <= next_s;
    end
  end

  assign axi_o = s.axi;
  assign mem_o = s.mem;
  assign flash_o = s.fl;

endmodule : fmc_top

// ### dv/fmc_top_asserts.sv
module fmc_top_asserts #(
  parameter int POWERUP_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire fmc_pkg::fmc_axi_req_t axi_i,
  input wire fmc_pkg::fmc_axi_rsp_t axi_o,
  input wire fmc_pkg::fmc_mem_req_t mem_i,
  input wire fmc_pkg::fmc_mem_rsp_t mem_o,
  input wire fmc_pkg::fmc_flash_ctl_t flash_o,
  input wire logic security_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  int unsigned up_cnt;
  // edges seen since reset release, saturating at the power-up length
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_cnt <= 0;
    end else if (up_cnt < POWERUP_CYCLES) begin
      up_cnt <= up_cnt + 1;
    end
  end
  sequence s_b_done;
    axi_o.bvalid && axi_i.bready;
  endsequence
  sequence s_erase;
    flash_o.op_valid && flash_o.op == fmc_pkg::FMC_CMD_ERASE_ROW;
  endsequence
  chk_up_stall: assert property (up_cnt < POWERUP_CYCLES |-> !mem_o.ack)
    else $error("memory ack during power-up");
  chk_ack_pulse: assert property (mem_o.ack |=> !mem_o.ack)
    else $error("memory ack longer than one cycle");
  chk_b_hold: assert property (axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid && $stable(axi_o.rdata))
    else $error("read response dropped early");
  chk_ready_back: assert property (s_b_done |=> axi_o.awready && axi_o.wready)
    else $error("write channels not ready after response");
  chk_ar_answer: assert property (axi_i.arvalid && axi_o.arready |=> axi_o.rvalid)
    else $error("read not answered next cycle");
  chk_sec_err: assert property (mem_o.ack && mem_i.dbg && security_i |-> mem_o.err)
    else $error("debug access served while secured");
  chk_erase_stall: assert property (s_erase |=> (!mem_o.ack || mem_o.err)[*8])
    else $error("memory access served during erase");
  chk_op_pulse: assert property (flash_o.op_valid |=> !flash_o.op_valid)
    else $error("operation start longer than one cycle");
endmodule : fmc_top_asserts

bind fmc_top fmc_top_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES)) fmc_top_asserts_inst (
  .core_clk_i, .rst_i, .axi_i, .axi_o, .mem_i, .mem_o, .flash_o, .security_i
);

// ### dv/fmc_flash_model.sv
module fmc_flash_model (
  input wire logic clk_i,
  input wire fmc_pkg::fmc_flash_ctl_t flash_i,
  output logic [31:0] rdata_o,
  output int op_cnt_o,
  output logic [6:0] op_o,
  output logic [31:0] op_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // address-derived data, garbled while powered down
  always_comb begin
    rdata_o = flash_i.raddr ^ 32'h5a3c_0000;
    if (flash_i.lowpower) begin
      rdata_o = ~rdata_o;
    end
  end
  initial op_cnt_o = 0;
  // records every operation start
  always @(posedge clk_i) begin
    if (flash_i.op_valid) begin
      op_cnt_o <= op_cnt_o + 1;
      op_o <= flash_i.op;
      op_addr_o <= flash_i.op_addr;
    end
  end
endmodule : fmc_flash_model

// ### dv/fmc_top_tb.sv
module fmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'h5a3c_0000;
  logic core_clk_i;
  logic rst_i;
  fmc_pkg::fmc_axi_req_t ax;
  fmc_pkg::fmc_axi_rsp_t axi_o;
  fmc_pkg::fmc_mem_req_t mr;
  fmc_pkg::fmc_mem_rsp_t mem_o;
  fmc_pkg::fmc_flash_ctl_t flash_o;
  logic [31:0] frd;
  logic gwp, slp, sec, me;
  logic [2:0] bp = 3'h7, ee = 3'h7;
  logic [6:0] op;
  logic [31:0] opa, rv;
  int op_cnt, n, k;
  int err_count = 0;
  int samples_checked = 0;

  fmc_top #(.POWERUP_CYCLES(8), .PROG_CYCLES(20), .ERASE_CYCLES(30)) fmc_top_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .axi_i(ax), .axi_o(axi_o), .mem_i(mr), .mem_o(mem_o),
    .flash_rdata_i(frd), .flash_o(flash_o), .guard_wp_i(gwp), .sleep_i(slp), .security_i(sec),
    .boot_protect_size_i(bp), .eeprom_size_i(ee), .lock_default_i(16'h0003));
  fmc_flash_model fmc_flash_model_inst (.clk_i(core_clk_i), .flash_i(flash_o), .rdata_o(frd),
    .op_cnt_o(op_cnt), .op_o(op), .op_addr_o(opa));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk_i);
    ax.awaddr <= {24'h0, a};
    ax.wdata <= d;
    ax.wstrb <= 4'hf;
    ax.awvalid <= 1'b1;
    ax.wvalid <= 1'b1;
    ax.bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (axi_o.awready) ax.awvalid <= 1'b0;
      if (axi_o.wready) ax.wvalid <= 1'b0;
    end while (!axi_o.bvalid && n < 200);
    ax.bready <= 1'b0;
    chk("bresp", {29'h0, 1'b1, e}, {29'h0, axi_o.bvalid, axi_o.bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    ax.araddr <= {24'h0, a};
    ax.arvalid <= 1'b1;
    ax.rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
      if (axi_o.arready) ax.arvalid <= 1'b0;
    end while (!axi_o.rvalid && n < 200);
    ax.rready <= 1'b0;
    chk($sformatf("reg %h", a), e, axi_o.rdata);
  endtask : rd

  task automatic cmd(input logic [6:0] c);
    wr(fmc_pkg::FMC_OFS_CMD, {16'h0, fmc_pkg::FMC_CMD_KEY, 1'b0, c}, fmc_pkg::FMC_RESP_OKAY);
  endtask : cmd

  task automatic mem(input logic w, input logic g, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    mr.req <= 1'b1;
    mr.we <= w;
    mr.dbg <= g;
    mr.addr <= a;
    mr.wdata <= d;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!mem_o.ack && n < 500);
    mr.req <= 1'b0;
    rv = mem_o.rdata;
    me = mem_o.err;
  endtask : mem

  task automatic t_boot();
    rd(fmc_pkg::FMC_OFS_INTERRUPT_FLAG_REGISTER, 32'h0);
    mem(0, 0, 32'h100, 0);
    chk("rdata", 32'h100 ^ PAT, rv);
    chk("err", 32'h0, {31'h0, me});
    rd(fmc_pkg::FMC_OFS_INTERRUPT_FLAG_REGISTER, 32'h1);
    rd(fmc_pkg::FMC_OFS_CTRLB, fmc_pkg::FMC_CTRLB_RST);
    rd(fmc_pkg::FMC_OFS_LOCK, 32'h3);
    wr(8'h40, 32'h0, fmc_pkg::FMC_RESP_SLVERR);
    mem(0, 0, fmc_pkg::FMC_AUX_BASE, 0);
    chk("aux", fmc_pkg::FMC_AUX_BASE ^ PAT, rv);
    mem(0, 0, 32'h0100_0000, 0);
    chk("unmapped", 32'h1, {31'h0, me});
  endtask : t_boot

  task automatic t_ws();
    for (int w = 0; w < 3; w++) begin
      wr(fmc_pkg::FMC_OFS_CTRLB, 32'h80 | 32'(w << 1), fmc_pkg::FMC_RESP_OKAY);
      mem(0, 0, 32'h8000 + 32'(w * 4), 0);
      chk("waits", 32'(w + 3), 32'(n));
      chk("rdata", (32'h8000 + 32'(w * 4)) ^ PAT, rv);
    end
  endtask : t_ws

  task automatic t_lock();
    wr(fmc_pkg::FMC_OFS_ADDR, 32'h8000, fmc_pkg::FMC_RESP_OKAY);
    cmd(fmc_pkg::FMC_CMD_LOCK_REGION);
    rd(fmc_pkg::FMC_OFS_LOCK, 32'h7);
    wr(fmc_pkg::FMC_OFS_ADDR, 32'h0, fmc_pkg::FMC_RESP_OKAY);
    cmd(fmc_pkg::FMC_CMD_UNLOCK_REGION);
    rd(fmc_pkg::FMC_OFS_LOCK, 32'h6);
    wr(fmc_pkg::FMC_OFS_LOCK, 32'h0, fmc_pkg::FMC_RESP_SLVERR);
    wr(fmc_pkg::FMC_OFS_ADDR, 32'h4000, fmc_pkg::FMC_RESP_OKAY);
    k = op_cnt;
    cmd(fmc_pkg::FMC_CMD_ERASE_ROW);
    rd(fmc_pkg::FMC_OFS_STATUS, 32'h4);
    chk("ops", 32'(k), 32'(op_cnt));
    wr(fmc_pkg::FMC_OFS_STATUS, 32'h4, fmc_pkg::FMC_RESP_OKAY);
    rd(fmc_pkg::FMC_OFS_STATUS, 32'h0);
  endtask : t_lock

  task automatic t_busy();
    wr(fmc_pkg::FMC_OFS_ADDR, 32'h1_0140, fmc_pkg::FMC_RESP_OKAY);
    k = op_cnt;
    cmd(fmc_pkg::FMC_CMD_ERASE_ROW);
    rd(fmc_pkg::FMC_OFS_INTERRUPT_FLAG_REGISTER, 32'h0);
    cmd(fmc_pkg::FMC_CMD_LOCK_REGION);
    mem(0, 0, 32'h200, 0);
    chk("stall", 32'h1, {31'h0, n > 10});
    chk("rdata", 32'h200 ^ PAT, rv);
    chk("op", {25'h0, fmc_pkg::FMC_CMD_ERASE_ROW}, {25'h0, op});
    chk("row", 32'h1_0100, opa);
    chk("ops", 32'(k + 1), 32'(op_cnt));
    rd(fmc_pkg::FMC_OFS_LOCK, 32'h6);
    wr(fmc_pkg::FMC_OFS_ADDR, fmc_pkg::FMC_RWW_BASE, fmc_pkg::FMC_RESP_OKAY);
    cmd(fmc_pkg::FMC_CMD_RWW_ERASE_ROW);
    mem(0, 0, 32'h300, 0);
    chk("no stall", 32'h5, 32'(n));
  endtask : t_busy

  task automatic t_auto();
    wr(fmc_pkg::FMC_OFS_CTRLB, 32'h4, fmc_pkg::FMC_RESP_OKAY);
    k = op_cnt;
    for (int i = 0; i < 16; i++) begin
      mem(1, 0, 32'h2_0000 + 32'(i * 4), 32'(i));
    end
    repeat (5) @(posedge core_clk_i);
    chk("ops", 32'(k + 1), 32'(op_cnt));
    chk("op", {25'h0, fmc_pkg::FMC_CMD_WRITE_PAGE}, {25'h0, op});
    chk("page", 32'h2_0000, opa);
    rd(fmc_pkg::FMC_OFS_ADDR, 32'h2_003c);
  endtask : t_auto

  task automatic t_misc();
    gwp <= 1'b1;
    wr(fmc_pkg::FMC_OFS_CTRLB, 32'h0, fmc_pkg::FMC_RESP_SLVERR);
    wr(fmc_pkg::FMC_OFS_ADDR, 32'h0, fmc_pkg::FMC_RESP_SLVERR);
    wr(fmc_pkg::FMC_OFS_INTERRUPT_FLAG_REGISTER, 32'h2, fmc_pkg::FMC_RESP_OKAY);
    wr(fmc_pkg::FMC_OFS_STATUS, 32'h4, fmc_pkg::FMC_RESP_OKAY);
    rd(fmc_pkg::FMC_OFS_CTRLB, 32'h4);
    gwp <= 1'b0;
    sec <= 1'b1;
    mem(0, 1, 32'h0, 0);
    chk("dbg err", 32'h1, {31'h0, me});
    mem(0, 0, 32'h40, 0);
    chk("rdata", 32'h40 ^ PAT, rv);
    sec <= 1'b0;
    wr(fmc_pkg::FMC_OFS_CTRLB, 32'h0, fmc_pkg::FMC_RESP_OKAY);
    slp <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk("lowpower", 32'h1, {31'h0, flash_o.lowpower});
    wr(fmc_pkg::FMC_OFS_CTRLB, 32'h300, fmc_pkg::FMC_RESP_OKAY);
    repeat (3) @(posedge core_clk_i);
    chk("lowpower", 32'h0, {31'h0, flash_o.lowpower});
    slp <= 1'b0;
    bp <= 3'h6;
    ee <= 3'h6;
    k = op_cnt;
    mem(1, 0, 32'h100, 0);
    cmd(fmc_pkg::FMC_CMD_ERASE_ROW);
    wr(fmc_pkg::FMC_OFS_ADDR, 32'h3ff00, fmc_pkg::FMC_RESP_OKAY);
    cmd(fmc_pkg::FMC_CMD_LOCK_REGION);
    cmd(fmc_pkg::FMC_CMD_ERASE_ROW);
    rd(fmc_pkg::FMC_OFS_STATUS, 32'h6);
    chk("ops", 32'(k + 2), 32'(op_cnt));
  endtask : t_misc

  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    ax = '0;
    mr = '0;
    gwp = 1'b0;
    slp = 1'b0;
    sec = 1'b0;
    rst_i = 1'b1;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_ws();
    t_lock();
    t_busy();
    t_auto();
    t_misc();
    finish_test();
  end

  initial begin
    #100us;
    err_count++;
    finish_test();
  end
endmodule : fmc_top_tb
